// ==== hbcr_pkg.sv ====
// Constants shared by the half-bridge control register bank.
// Assumes a 16-bit frame of address byte then data byte, shifted MSB first.
package hbcr_pkg;

	localparam int          BRIDGES      = 8;
	localparam int          FRAME_BITS   = 16;
	localparam int          BYTE_BITS    = 8;
	localparam int          CNT_W        = 5;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [7:0]  STATUS_BYTE  = 8'h00;
	localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

	// Address byte layout.
	localparam int          RW_BIT       = 7;
	localparam int          SEL_MSB      = 6;
	localparam int          SEL_LSB      = 2;
	localparam int          LAST_ADDRESS_TOKEN_BIT_BIT     = 1;
	localparam int          FIXED_BIT    = 0;

	// Register select codes in address bits 6 to 2.
	localparam logic [4:0]  SEL_SW_LO    = 5'h00;
	localparam logic [4:0]  SEL_SW_HI    = 5'h10;
	localparam logic [4:0]  SEL_PWM_LO   = 5'h18;
	localparam logic [4:0]  SEL_PWM_HI   = 5'h04;

	// PWM select field encodings.
	localparam logic [1:0]  PWM_NONE     = 2'h0;
	localparam logic [1:0]  PWM_CH1      = 2'h1;
	localparam logic [1:0]  PWM_CH2      = 2'h2;
	localparam logic [1:0]  PWM_CH3      = 2'h3;

	typedef enum logic [2:0] {
		HBCR_REG_SW_LO,
		HBCR_REG_SW_HI,
		HBCR_REG_PWM_LO,
		HBCR_REG_PWM_HI,
		HBCR_REG_NONE
	} hbcr_reg_type;

endpackage : hbcr_pkg

// ==== hbcr_sync.sv ====
// Two-stage synchroniser for pins arriving from outside the mclk_i domain.
// Assumes the inputs are quasi-static relative to mclk_i, as the SPI pins are.
`timescale 1ns/1ps
`default_nettype none

module hbcr_sync #(
	parameter int               WIDTH    = 3,
	parameter logic [WIDTH-1:0] INIT_VAL = '0
) (
	input  wire logic             mclk_i,
	input  wire logic             nrst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			meta   <= INIT_VAL;
			sync_o <= INIT_VAL;
		end else begin
			meta   <= next_meta;
			sync_o <= next_sync;
		end
	end

endmodule : hbcr_sync
`default_nettype wire

// ==== hbcr_regs.sv ====
// SPI-reached control register bank for eight half-bridges: switch enables and PWM channel select.
// Assumes an SPI master with idle-low clock, data sampled on rising and shifted on falling SCLK edges.
// SCLK must be at most an eighth of mclk_i so that both edges are seen after synchronisation.
// A frame that is not exactly sixteen clocks long writes nothing; the host has to send it again.
`timescale 1ns/1ps
`default_nettype none

module hbcr_regs
	import hbcr_pkg::*;
#(
	parameter int N_BRIDGES = hbcr_pkg::BRIDGES
) (
	input  wire logic                 mclk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 spi_csn_i,
	input  wire logic                 spi_sclk_i,
	input  wire logic                 spi_mosi_i,
	output var  logic                 spi_miso_o,
	output var  logic                 spi_miso_oe_o,
	output var  logic [N_BRIDGES-1:0] high_side_switch_o,
	output var  logic [N_BRIDGES-1:0] low_side_switch_o,
	output var  logic [2*N_BRIDGES-1:0] bridge_pwm_select_o
);
	import hbcr_pkg::*;

	typedef enum logic {
		HBCR_ST_IDLE,
		HBCR_ST_FRAME
	} hbcr_state_type;

	// Maps an address byte to a register; bit 1 carries the token and is ignored.
	function automatic hbcr_reg_type hbcr_decode(input logic [7:0] addr);
		hbcr_reg_type r;
		r = HBCR_REG_NONE;
		if (addr[FIXED_BIT]) begin
			case (addr[SEL_MSB:SEL_LSB])
				SEL_SW_LO:  r = HBCR_REG_SW_LO;
				SEL_SW_HI:  r = HBCR_REG_SW_HI;
				SEL_PWM_LO: r = HBCR_REG_PWM_LO;
				SEL_PWM_HI: r = HBCR_REG_PWM_HI;
				default:    r = HBCR_REG_NONE;
			endcase
		end
		return r;
	endfunction : hbcr_decode

	// Picks the byte shifted back during the data phase; unmapped selects read as a fixed value.
	function automatic logic [7:0] hbcr_readback(
		input hbcr_reg_type sel,
		input logic [7:0]   sw_lo_v,
		input logic [7:0]   sw_hi_v,
		input logic [7:0]   pwm_lo_v,
		input logic [7:0]   pwm_hi_v
	);
		logic [7:0] r;
		case (sel)
			HBCR_REG_SW_LO:  r = sw_lo_v;
			HBCR_REG_SW_HI:  r = sw_hi_v;
			HBCR_REG_PWM_LO: r = pwm_lo_v;
			HBCR_REG_PWM_HI: r = pwm_hi_v;
			default:         r = UNMAPPED_VAL;
		endcase
		return r;
	endfunction : hbcr_readback

	// Synchroniser lanes; the reset value matches the idle pins so no false edge follows reset.
	localparam int                SYNC_W    = 3;
	localparam int                LANE_CSN  = 2;
	localparam int                LANE_SCLK = 1;
	localparam int                LANE_MOSI = 0;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1) << LANE_CSN;

	logic [SYNC_W-1:0]  pins_sync;
	logic               csn_s;
	logic               sclk_s;
	logic               mosi_s;
	logic               sclk_d;
	logic               csn_d;
	logic               sclk_rise;
	logic               sclk_fall;
	logic               csn_fall;
	logic               csn_rise;

	hbcr_sync #(
		.WIDTH    (SYNC_W),
		.INIT_VAL (SYNC_IDLE)
	) u_sync (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.async_i ({spi_csn_i, spi_sclk_i, spi_mosi_i}),
		.sync_o  (pins_sync)
	);

	assign csn_s     = pins_sync[LANE_CSN];
	assign sclk_s    = pins_sync[LANE_SCLK];
	assign mosi_s    = pins_sync[LANE_MOSI];
	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;
	assign csn_fall  = ~csn_s & csn_d;
	assign csn_rise  = csn_s & ~csn_d;

	// Framing state, the four control registers and the shift paths of the link.
	hbcr_state_type     state;
	hbcr_state_type     next_state;
	logic [7:0]         sw_lo;
	logic [7:0]         sw_hi;
	logic [7:0]         pwm_lo;
	logic [7:0]         pwm_hi;
	logic [7:0]         next_sw_lo;
	logic [7:0]         next_sw_hi;
	logic [7:0]         next_pwm_lo;
	logic [7:0]         next_pwm_hi;
	logic [FRAME_BITS-1:0] rx_shift;
	logic [FRAME_BITS-1:0] next_rx_shift;
	logic [CNT_W-1:0]   bit_cnt;
	logic [CNT_W-1:0]   next_bit_cnt;
	logic [7:0]         tx_shift;
	logic [7:0]         next_tx_shift;
	logic               next_miso;
	logic               next_miso_oe;
	logic [N_BRIDGES-1:0]   next_hs;
	logic [N_BRIDGES-1:0]   next_ls;
	logic [2*N_BRIDGES-1:0] next_pwm_sel;
	logic [2*BYTE_BITS-1:0] sw_all;
	logic [7:0]         rx_addr;
	logic [7:0]         rx_data;
	hbcr_reg_type       rx_reg;
	hbcr_reg_type       load_reg;
	logic               wr_en;

	assign sw_all   = {sw_hi, sw_lo};
	assign rx_addr  = rx_shift[FRAME_BITS-1:BYTE_BITS];
	assign rx_data  = rx_shift[BYTE_BITS-1:0];
	assign rx_reg   = hbcr_decode(rx_addr);
	// The address byte is complete as its last bit arrives on mosi_s, on the same rising edge that shifts it into the low byte.
	assign load_reg = hbcr_decode({rx_shift[BYTE_BITS-2:0], mosi_s});

	// SPI framing: the status byte goes out while the address comes in, then the addressed register.
	always_comb begin
		next_state    = state;
		wr_en         = 1'b0;
		next_rx_shift = rx_shift;
		next_bit_cnt  = bit_cnt;
		next_tx_shift = tx_shift;
		next_miso     = spi_miso_o;
		next_miso_oe  = spi_miso_oe_o;
		case (state)
			HBCR_ST_IDLE: begin
				// MISO is released between frames so that other devices on the link can drive it.
				next_miso_oe = 1'b0;
				next_miso    = 1'b0;
				if (csn_fall) begin
					next_state    = HBCR_ST_FRAME;
					next_bit_cnt  = '0;
					next_rx_shift = '0;
					next_tx_shift = {STATUS_BYTE[BYTE_BITS-2:0], 1'b0};
					next_miso     = STATUS_BYTE[BYTE_BITS-1];
					next_miso_oe  = 1'b1;
				end
			end
			HBCR_ST_FRAME: begin
				if (csn_rise) begin
					next_state   = HBCR_ST_IDLE;
					next_miso_oe = 1'b0;
					next_miso    = 1'b0;
					// Short or long frames are dropped so a glitch cannot corrupt a register.
					if (bit_cnt == CNT_W'(FRAME_BITS) && rx_addr[RW_BIT]) begin
						wr_en = 1'b1;
					end
				end else begin
					if (sclk_rise) begin
						next_rx_shift = {rx_shift[FRAME_BITS-2:0], mosi_s};
						// The count saturates so an overlong frame can never wrap back to a legal length.
						if (bit_cnt != {CNT_W{1'b1}}) begin
							next_bit_cnt = bit_cnt + CNT_W'(1);
						end
						if (bit_cnt == CNT_W'(BYTE_BITS - 1)) begin
							// Reads return the current content; a read never touches it.
							next_tx_shift = hbcr_readback(load_reg, sw_lo, sw_hi, pwm_lo, pwm_hi);
						end
					end
					if (sclk_fall) begin
						next_miso     = tx_shift[BYTE_BITS-1];
						next_tx_shift = {tx_shift[BYTE_BITS-2:0], 1'b0};
					end
				end
			end
			default: next_state = HBCR_ST_IDLE;
		endcase
	end

	// Register file: only a complete host write moves a register, the device never clears one itself.
	always_comb begin
		next_sw_lo  = sw_lo;
		next_sw_hi  = sw_hi;
		next_pwm_lo = pwm_lo;
		next_pwm_hi = pwm_hi;
		if (wr_en) begin
			case (rx_reg)
				HBCR_REG_SW_LO:  next_sw_lo  = rx_data;
				HBCR_REG_SW_HI:  next_sw_hi  = rx_data;
				HBCR_REG_PWM_LO: next_pwm_lo = rx_data;
				HBCR_REG_PWM_HI: next_pwm_hi = rx_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			sw_lo  <= REG_RESET;
			sw_hi  <= REG_RESET;
			pwm_lo <= REG_RESET;
			pwm_hi <= REG_RESET;
		end else begin
			sw_lo  <= next_sw_lo;
			sw_hi  <= next_sw_hi;
			pwm_lo <= next_pwm_lo;
			pwm_hi <= next_pwm_hi;
		end
	end

	// Cross-conduction guard: both enables of a pair set leaves that bridge floating. The register
	// still keeps both bits, so the host reads back exactly what it wrote.
	function automatic logic [1:0] hbcr_interlock(input logic [1:0] pair);
		logic [1:0] on;
		on = pair;
		if (&pair) begin
			on = '0;
		end
		return on;
	endfunction : hbcr_interlock

	// Each bridge is judged on its own pair, so one bad pair never blanks its neighbours.
	for (genvar b = 0; b < N_BRIDGES; b++) begin : g_bridge
		logic [1:0] pair_on;
		assign pair_on    = hbcr_interlock(sw_all[2*b+1:2*b]);
		assign next_ls[b] = pair_on[0];
		assign next_hs[b] = pair_on[1];
	end

	assign next_pwm_sel = {pwm_hi, pwm_lo};

	// Edge detectors start from the idle levels of their pins so reset makes no false edge.
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			sclk_d <= 1'b0;
			csn_d  <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			csn_d  <= csn_s;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state         <= HBCR_ST_IDLE;
			rx_shift      <= '0;
			bit_cnt       <= '0;
			tx_shift      <= '0;
			spi_miso_o    <= 1'b0;
			spi_miso_oe_o <= 1'b0;
		end else begin
			state         <= next_state;
			rx_shift      <= next_rx_shift;
			bit_cnt       <= next_bit_cnt;
			tx_shift      <= next_tx_shift;
			spi_miso_o    <= next_miso;
			spi_miso_oe_o <= next_miso_oe;
		end
	end

	// The switch outputs lag the registers by one cycle; nothing downstream needs them sooner.
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			high_side_switch_o  <= '0;
			low_side_switch_o   <= '0;
			bridge_pwm_select_o <= '0;
		end else begin
			high_side_switch_o  <= next_hs;
			low_side_switch_o   <= next_ls;
			bridge_pwm_select_o <= next_pwm_sel;
		end
	end

endmodule : hbcr_regs
`default_nettype wire

// ==== hbcr_regs_props.sv ====
// Port-level checks for the half-bridge control register bank.
// Assumes it is bound into hbcr_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module hbcr_regs_props #(
	parameter int N_BRIDGES = 8
) (
	input wire logic                   mclk_i,
	input wire logic                   nrst_i,
	input wire logic                   spi_csn_i,
	input wire logic                   spi_sclk_i,
	input wire logic                   spi_mosi_i,
	input wire logic                   spi_miso_o,
	input wire logic                   spi_miso_oe_o,
	input wire logic [N_BRIDGES-1:0]   high_side_switch_o,
	input wire logic [N_BRIDGES-1:0]   low_side_switch_o,
	input wire logic [2*N_BRIDGES-1:0] bridge_pwm_select_o
);
	logic [2:0] hi_cnt;
	logic [2:0] next_hi_cnt;
	// Cycles since chip select rose; it saturates so that long idle gaps never wrap.
	always_comb begin
		next_hi_cnt = (!nrst_i || !spi_csn_i) ? 3'h0 : (hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1;
	end
	always_ff @(posedge mclk_i) begin
		hi_cnt <= next_hi_cnt;
	end
	a_reset_clear:
		assert property (@(posedge mclk_i) !nrst_i |=> !spi_miso_oe_o && high_side_switch_o == '0
			&& low_side_switch_o == '0 && bridge_pwm_select_o == '0) else $error("reset outputs");
	a_no_cross:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			(high_side_switch_o & low_side_switch_o) == '0) else $error("cross current");
	a_out_hold:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			$changed({high_side_switch_o, low_side_switch_o, bridge_pwm_select_o})
			|-> spi_csn_i && hi_cnt inside {[3'h3:3'h6]}) else $error("output moved");
	a_oe_start:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			$fell(spi_csn_i) |-> ##[2:5] spi_miso_oe_o) else $error("no drive");
	a_oe_end:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			$rose(spi_csn_i) |-> ##[2:6] !spi_miso_oe_o) else $error("drive stuck");
	a_oe_in_frame:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			spi_miso_oe_o |-> hi_cnt < 3'h6) else $error("drive idle");
	a_status_first:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			$rose(spi_miso_oe_o) |-> !spi_miso_o) else $error("status bit");
	a_miso_on_fall:
		assert property (@(posedge mclk_i) disable iff (!nrst_i)
			spi_miso_oe_o && $past(spi_miso_oe_o) && $changed(spi_miso_o)
			|-> !$past(spi_sclk_i, 2)) else $error("miso timing");
endmodule : hbcr_regs_props
bind hbcr_regs hbcr_regs_props #(.N_BRIDGES(N_BRIDGES)) chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
	.spi_csn_i(spi_csn_i), .spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
	.spi_miso_oe_o(spi_miso_oe_o), .high_side_switch_o(high_side_switch_o),
	.low_side_switch_o(low_side_switch_o), .bridge_pwm_select_o(bridge_pwm_select_o));
`default_nettype wire

// ==== hbcr_host.sv ====
// Host model: SPI master in mode 0 that sends frames on command of the bench.
// Assumes mclk_i is the device clock; every pin moves 2 ns after its edge.
`timescale 1ns/1ps
`default_nettype none
module hbcr_host (
	input  wire logic mclk_i,
	input  wire logic miso_i,
	output var  logic csn_o,
	output var  logic sclk_o,
	output var  logic mosi_o
);
	initial begin
		csn_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge mclk_i);
		#2;
	endtask : gap
	// Frames shorter than 16 bits are only sent where the bench expects a refusal.
	task automatic frame(input logic [15:0] tx, input int nb, input int hp, output logic [15:0] rx);
		rx = 16'h0000;
		gap(1);
		csn_o = 1'b0;
		gap(hp);
		for (int i = 15; i > 15 - nb; i--) begin
			mosi_o = tx[i];
			gap(hp);
			sclk_o = 1'b1;
			gap(hp);
			// Read late in the high phase, well clear of the device's next change.
			rx = {rx[14:0], miso_i};
			sclk_o = 1'b0;
		end
		gap(hp);
		csn_o = 1'b1;
		mosi_o = ~mosi_o;
		gap(10);
	endtask : frame
endmodule : hbcr_host
`default_nettype wire

// ==== test_half_bridge_ctrl_regs.sv ====
// Self-checking bench for the half-bridge control register bank.
// Assumes hbcr_host drives the link and the checker is bound into the design.
`timescale 1ns/1ps
`default_nettype none
module test_half_bridge_ctrl_regs;
	import hbcr_pkg::*;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	wire logic   csn, sclk, mosi, miso, oe, miso_pin;
	wire logic [7:0]  hs, ls;
	wire logic [15:0] pwm;
	int          n_fail = 0;
	int          tests_run = 0;
	logic [7:0]  m [4];
	logic [4:0]  sel [4] = '{SEL_SW_LO, SEL_SW_HI, SEL_PWM_LO, SEL_PWM_HI};
	always #20 mclk_i = ~mclk_i;
	// MISO floats when released, so the bench shows a changing level there instead.
	assign miso_pin = oe ? miso : ~mosi;
	hbcr_regs dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .spi_csn_i(csn), .spi_sclk_i(sclk),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe), .high_side_switch_o(hs),
		.low_side_switch_o(ls), .bridge_pwm_select_o(pwm));
	hbcr_host host_u (.mclk_i(mclk_i), .miso_i(miso_pin), .csn_o(csn), .sclk_o(sclk), .mosi_o(mosi));
	task automatic end_of_test();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [15:0] sw(input logic [15:0] v);
		logic [15:0] r;
		for (int b = 0; b < 8; b++) begin
			r[b+8] = v[2*b+1] & ~v[2*b];
			r[b] = v[2*b] & ~v[2*b+1];
		end
		return r;
	endfunction : sw
	task automatic chk_regs();
		logic [15:0] rx;
		for (int r = 0; r < 4; r++) begin
			host_u.frame({1'b0, sel[r], 2'h3, 8'hFF}, 16, 4, rx);
			chk("read", {STATUS_BYTE, m[r]}, rx);
		end
		chk("switch", sw({m[1], m[0]}), {hs, ls});
		chk("pwm", {m[3], m[2]}, pwm);
	endtask : chk_regs
	task automatic wr(input int r, input logic [7:0] d, input logic last_address_token_bit, input int hp);
		logic [15:0] rx;
		host_u.frame({1'b1, sel[r], last_address_token_bit, 1'b1, d}, 16, hp, rx);
		chk("echo", {STATUS_BYTE, m[r]}, rx);
		m[r] = d;
	endtask : wr
	task automatic t_refuse();
		logic [15:0] rx;
		host_u.frame({1'b1, sel[0], 2'h1, 8'h0F}, 15, 4, rx);
		host_u.frame({1'b1, sel[1], 2'h0, 8'hF0}, 16, 4, rx);
		host_u.frame({1'b1, 5'h1F, 2'h1, 8'hAA}, 16, 4, rx);
		host_u.frame({1'b0, 5'h1F, 2'h1, 8'hAA}, 16, 4, rx);
		chk("unmapped", {STATUS_BYTE, UNMAPPED_VAL}, rx);
		chk_regs();
	endtask : t_refuse
	// A reset in mid-run must bring registers and outputs back to their defaults.
	task automatic t_reset();
		@(posedge mclk_i);
		#2 nrst_i = 1'b0;
		repeat (20) @(posedge mclk_i);
		#2 nrst_i = 1'b1;
		m = '{default: REG_RESET};
		repeat (4) @(posedge mclk_i);
		chk_regs();
	endtask : t_reset
	// About four times the expected run of some five thousand clock cycles.
	initial begin
		#800000;
		n_fail++;
		end_of_test();
	end
	initial begin
		m = '{default: REG_RESET};
		repeat (20) @(posedge mclk_i);
		#2 nrst_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		chk_regs();
		wr(0, 8'h99, 1'b0, 4);
		wr(1, 8'h66, 1'b1, 4);
		wr(2, 8'hE4, 1'b1, 4);
		wr(3, 8'h1B, 1'b0, 4);
		chk_regs();
		wr(0, 8'hFF, 1'b0, 4);
		wr(1, 8'hC3, 1'b1, 4);
		chk_regs();
		t_refuse();
		t_reset();
		wr(2, 8'h5A, 1'b0, 4);
		chk_regs();
		end_of_test();
	end
endmodule : test_half_bridge_ctrl_regs
`default_nettype wire
